// ### verilog/drrt_pkg.sv
// Package: constants and carrier types of the delayed reset and restore trigger
package drrt_pkg;
  localparam logic [7:0] DRRT_SLAVE_ADDR_DEFAULT = 8'h0b;
  localparam logic [15:0] DRRT_OFFSET_COUNTDOWN = 16'h1037;
  localparam logic [15:0] DRRT_OFFSET_ACTION = 16'h1038;
  localparam logic [15:0] DRRT_COUNTDOWN_RESET = 16'h0000;
  localparam logic [15:0] DRRT_ACTION_RESET = 16'h0000;
  localparam logic [15:0] DRRT_COUNTDOWN_MAX = 16'h00ff;
  localparam logic [15:0] DRRT_ACTION_MAX = 16'h0001;
  localparam int DRRT_CLK_HZ = 10000000;
  localparam int DRRT_TICK_MS = 100;
  localparam int DRRT_TICK_CYCLES = DRRT_CLK_HZ / 1000 * DRRT_TICK_MS;

  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] slaveAddr;
    logic [15:0] regAddr;
    logic [15:0] wrData;
  } drrt_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdData;
  } drrt_rsp_type;
endpackage

// ### verilog/drrt_top.sv
// Module: delayed reset and factory restore trigger behind two holding registers
`timescale 1ns/100ps
module drrt_top
  import drrt_pkg::*;
#(
  parameter int TICK_CYCLES = DRRT_TICK_CYCLES,
  parameter logic [7:0] SLAVE_ADDR = DRRT_SLAVE_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire drrt_req_type req,
  output drrt_rsp_type rsp,
  output logic restorePulse,
  output logic rebootPulse,
  output logic countdownBusy
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rstSync;
  logic rstInt_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstInt_n = rstSync[1];

  // ----------------------------------------
  // Derived constants
  // ----------------------------------------
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic isOurs(input drrt_req_type r, input logic [7:0] addr);
    return r.slaveAddr == addr;
  endfunction

  function automatic logic isAccess(input drrt_req_type r, input logic [7:0] addr);
    return isOurs(r, addr) && (r.wrStrobe || r.rdStrobe);
  endfunction

  function automatic logic isRegister(input drrt_req_type r, input logic [15:0] offset);
    return r.regAddr == offset;
  endfunction

  // ----------------------------------------
  // Register access decode
  // ----------------------------------------
  logic addrHit;
  logic accessTaken;
  logic hitCountdown;
  logic hitAction;
  logic hitNone;
  logic wrCountdown;
  logic wrAction;
  logic rdCountdown;
  logic rdAction;

  assign addrHit = isOurs(req, SLAVE_ADDR);
  assign accessTaken = isAccess(req, SLAVE_ADDR);
  assign hitCountdown = isRegister(req, DRRT_OFFSET_COUNTDOWN);
  assign hitAction = isRegister(req, DRRT_OFFSET_ACTION);
  assign hitNone = !(hitCountdown || hitAction);
  assign wrCountdown = addrHit && req.wrStrobe && hitCountdown;
  assign wrAction = addrHit && req.wrStrobe && hitAction;
  assign rdCountdown = addrHit && req.rdStrobe && hitCountdown;
  assign rdAction = addrHit && req.rdStrobe && hitAction;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [15:0] countdown;
  logic [15:0] next_countdown;
  logic action;
  logic next_action;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] next_rdData;

  always_comb begin
    next_rdData = 16'h0;
    if (rdCountdown) begin
      next_rdData = countdown;
    end else if (rdAction) begin
      next_rdData = {15'h0, action};
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  drrt_rsp_type next_rsp;

  always_comb begin
    next_rsp.ack = accessTaken;
    next_rsp.err = accessTaken && hitNone;
    next_rsp.rdData = next_rdData;
  end

  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  // ----------------------------------------
  // Action selector
  // ----------------------------------------
  always_comb begin
    next_action = action;
    if (wrAction) begin
      next_action = req.wrData[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      action <= DRRT_ACTION_RESET[0];
    end else begin
      action <= next_action;
    end
  end

  // ----------------------------------------
  // 100 ms tick divider
  // ----------------------------------------
  logic [31:0] tickCount;
  logic [31:0] next_tickCount;
  logic tickWrap;
  logic tick;

  assign tickWrap = tickCount == TICK_LAST;
  assign tick = tickWrap && !wrCountdown;

  always_comb begin
    next_tickCount = tickCount + 32'h1;
    if (wrCountdown || tickWrap) begin
      next_tickCount = 32'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      tickCount <= 32'h0;
    end else begin
      tickCount <= next_tickCount;
    end
  end

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  always_comb begin
    next_countdown = countdown;
    if (wrCountdown) begin
      next_countdown = req.wrData & DRRT_COUNTDOWN_MAX;
    end else if (tick && countdown != 16'h0) begin
      next_countdown = countdown - 16'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      countdown <= DRRT_COUNTDOWN_RESET;
    end else begin
      countdown <= next_countdown;
    end
  end

  // ----------------------------------------
  // Busy flag
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      countdownBusy <= 1'b0;
    end else begin
      countdownBusy <= next_countdown != 16'h0;
    end
  end

  // ----------------------------------------
  // Expiry and actions
  // ----------------------------------------
  logic expire;
  logic next_restorePulse;
  logic next_rebootPulse;

  assign expire = tick && countdown == 16'h1;
  assign next_restorePulse = expire && action;
  assign next_rebootPulse = expire && !action;

  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      restorePulse <= 1'b0;
    end else begin
      restorePulse <= next_restorePulse;
    end
  end

  always_ff @(posedge sys_clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      rebootPulse <= 1'b0;
    end else begin
      rebootPulse <= next_rebootPulse;
    end
  end

endmodule

// ### verif/drrt_master.sv
// Modbus master model issuing one-cycle holding register requests
`timescale 1ns/100ps
module drrt_master
  import drrt_pkg::*;
(
  input wire logic sys_clk,
  output drrt_req_type req
);
  initial req = '0;
  task xfer(input logic w, input logic [7:0] s, input logic [15:0] a, d);
    @(negedge sys_clk);
    req <= {w, !w, s, a, d};
    @(negedge sys_clk);
    req <= {2'b00, ~req[39:0]};
  endtask
endmodule

// ### verif/drrt_monitor.sv
// Port-level checks of the trigger block
`timescale 1ns/100ps
module drrt_monitor
  import drrt_pkg::*;
#(parameter int TICK_CYCLES = 10) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire drrt_req_type req,
  input wire drrt_rsp_type rsp,
  input wire logic restorePulse,
  input wire logic rebootPulse,
  input wire logic countdownBusy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire tk = (req.wrStrobe | req.rdStrobe) && req.slaveAddr == DRRT_SLAVE_ADDR_DEFAULT;
  wire cw = tk && req.wrStrobe && req.regAddr == DRRT_OFFSET_COUNTDOWN;
  ack_taken_a: assert property (tk |=> rsp.ack) else $error("no ack");
  ack_stray_a: assert property (!tk |=> !rsp.ack) else $error("stray ack");
  busy_load_a: assert property (cw && req.wrData[7:0] != 0 |=> countdownBusy) else $error("no load");
  zero_stop_a: assert property (cw && req.wrData[7:0] == 0 |=> !countdownBusy) else $error("zero runs");
  tick_len_a: assert property (cw && req.wrData[7:0] == 1 |-> ##TICK_CYCLES countdownBusy ##1 !countdownBusy)
    else $error("tick length");
  restore_end_a: assert property (restorePulse |-> !rebootPulse && !countdownBusy) else $error("restore");
  expiry_act_a: assert property ($fell(countdownBusy) && !$past(req.wrStrobe) |-> ##[0:1] (restorePulse | rebootPulse))
    else $error("no action");
  pulse_once_a: assert property (restorePulse | rebootPulse |=> !(restorePulse | rebootPulse)) else $error("long");
  cover property (restorePulse);
  cover property (rebootPulse);
  cover property (rsp.err);
endmodule
bind drrt_top drrt_monitor #(.TICK_CYCLES(TICK_CYCLES)) drrt_monitor_inst(.sys_clk, .rst_n, .req, .rsp, .restorePulse,
  .rebootPulse, .countdownBusy);

// ### verif/delayed_reset_restore_trigger_test.sv
// Self-checking bench of the trigger block
`timescale 1ns/100ps
module delayed_reset_restore_trigger_test;
  import drrt_pkg::*;
  logic sys_clk = 0;
  logic rst_n = 0;
  drrt_req_type req;
  drrt_rsp_type rsp;
  logic restorePulse, rebootPulse, countdownBusy;
  logic [20:0] expQ[$];
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] rng = 1108;
  logic [15:0] n;
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  always #50 sys_clk = ~sys_clk;
  drrt_top #(.TICK_CYCLES(10)) drrt_top_inst(.sys_clk, .rst_n, .req, .rsp, .restorePulse, .rebootPulse, .countdownBusy);
  drrt_master drrt_master_inst(.sys_clk, .req);
  task chk(input logic [20:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task acc(input logic w, input logic [7:0] s, input logic [15:0] a, d, input logic [20:0] e);
    if (s == DRRT_SLAVE_ADDR_DEFAULT) expQ.push_back(e);
    drrt_master_inst.xfer(w, s, a, d);
  endtask
  always @(negedge sys_clk) begin
    logic [20:0] e;
    if (rsp.ack | restorePulse | rebootPulse) begin
      e = expQ.size() ? expQ.pop_front() : '1;
      chk({e[20], rsp.ack, restorePulse, rebootPulse, rsp.err, e[20] ? rsp.rdData : 16'h0}, e);
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      conclude;
    end
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1;
    repeat (4) @(negedge sys_clk);
    acc(0, 8'h0b, DRRT_OFFSET_COUNTDOWN, 16'h0, 21'h180000);
    acc(1, 8'h0c, DRRT_OFFSET_COUNTDOWN, 16'h5, 21'h0);
    chk(21'(countdownBusy), 21'h0);
    acc(0, 8'h0b, 16'h1039, 16'h0, 21'h190000);
    for (int k = 0; k < 2; k++) begin
      rng = xorshift(rng);
      n = k ? 16'h1 : 16'h2 + 16'(rng[1:0]);
      acc(1, 8'h0b, DRRT_OFFSET_ACTION, 16'(!k), 21'h080000);
      acc(1, 8'h0b, DRRT_OFFSET_COUNTDOWN, n, 21'h080000);
      acc(1, 8'h0b, DRRT_OFFSET_ACTION, 16'(k), 21'h080000);
      expQ.push_back({2'b00, k[0], !k[0], 17'h0});
      chk(21'(countdownBusy), 21'h1);
      repeat (n * 10 - 4) @(negedge sys_clk);
      chk(21'(countdownBusy), 21'h1);
      repeat (8) @(negedge sys_clk);
      chk(21'(countdownBusy), 21'h0);
    end
    acc(1, 8'h0b, DRRT_OFFSET_COUNTDOWN, 16'h0, 21'h080000);
    acc(0, 8'h0b, DRRT_OFFSET_ACTION, 16'h0, 21'h180001);
    repeat (30) @(negedge sys_clk);
    chk(21'(expQ.size()), 21'h0);
    conclude;
  end
endmodule
